/* sbwm_defs.svh */
/*
 * sbwm_defs.svh: constants for the byte lane write mask block.
 * assumes: included by its bare name from every design file that needs it.
 */
`ifndef SBWM_DEFS_SVH
`define SBWM_DEFS_SVH

// ****************************************
// word and lane geometry
// ****************************************
`define SBWM_WORD_W 18
`define SBWM_ADDR_W 4
`define SBWM_SEL_W 4
`define SBWM_LANE_W_NARROW 4
`define SBWM_LANE_W_WIDE 9
`define SBWM_NARROW_WORD 8

// ****************************************
// idle values
// ****************************************
`define SBWM_SEL_IDLE 4'hf

`endif

/* sbwm_pkg.sv */
/*
 * sbwm_pkg: types shared by the byte lane write mask modules.
 * assumes: nothing beyond a SystemVerilog compiler.
 */
package sbwm_pkg;

	// ****************************************
	// beat kinds
	// ****************************************
	typedef enum logic [1:0] {
		SBWM_BEAT_NONE,
		SBWM_BEAT_FIRST,
		SBWM_BEAT_SECOND
	} sbwm_beat_e;

endpackage : sbwm_pkg

/* sbwm_lane_if.sv */
/*
 * sbwm_lane_if: carries lane selects to the mask expander and the bit enables back.
 * assumes: clk and rst_n are the top module's clock and reset.
 */
`timescale 1ns/10ps
`include "sbwm_defs.svh"

interface sbwm_lane_if #(
	parameter int WORD_W = `SBWM_WORD_W
);
	logic clk;
	logic rst_n;
	logic [`SBWM_SEL_W-1:0] sel_n;
	logic [WORD_W-1:0] bit_en;

	modport ctrl (output clk, output rst_n, output sel_n, input bit_en);
	modport lane (input clk, input rst_n, input sel_n, output bit_en);
endinterface : sbwm_lane_if

/* sbwm_lane_mask.sv */
/*
 * sbwm_lane_mask: expands active-low lane selects into per-bit write enables.
 * assumes: WORD_W is 8, 9, 18 or 36; unused select bits are ignored.
 */
`timescale 1ns/10ps
`include "sbwm_defs.svh"

module sbwm_lane_mask #(
	parameter int WORD_W = `SBWM_WORD_W
) (
	sbwm_lane_if.lane m
);
	localparam int LANE_W = (WORD_W == `SBWM_NARROW_WORD) ?
		`SBWM_LANE_W_NARROW : `SBWM_LANE_W_WIDE;

	// ****************************************
	// per-bit lane expansion
	// ****************************************
	genvar i;
	generate
		for (i = 0; i < WORD_W; i = i + 1) begin : g_bit
			// R01 R02 R03 R04 R05 R06 R07 R08 lane to bits
			assign m.bit_en[i] = ~m.sel_n[i / LANE_W];
		end
	endgenerate

	// ****************************************
	// checks per word width
	// ****************************************
	generate
		if (WORD_W == 8 || WORD_W == 18) begin : g_two
			localparam int H = WORD_W / 2;
			a_both_low: assert property (@(posedge m.clk) disable iff (!m.rst_n) // R01
				m.sel_n[1:0] == 2'h0 |-> &m.bit_en) else $error("both low not full");
			a_lower_only: assert property (@(posedge m.clk) disable iff (!m.rst_n) // R02
				m.sel_n[1:0] == 2'h2 |-> (&m.bit_en[H-1:0]) && !(|m.bit_en[WORD_W-1:H]))
				else $error("lower half mask wrong");
			a_upper_only: assert property (@(posedge m.clk) disable iff (!m.rst_n) // R03
				m.sel_n[1:0] == 2'h1 |-> (&m.bit_en[WORD_W-1:H]) && !(|m.bit_en[H-1:0]))
				else $error("upper half mask wrong");
			a_both_high: assert property (@(posedge m.clk) disable iff (!m.rst_n) // R04
				m.sel_n[1:0] == 2'h3 |-> m.bit_en == '0) else $error("both high wrote");
		end else if (WORD_W == 9) begin : g_one
			a_single_sel: assert property (@(posedge m.clk) disable iff (!m.rst_n) // R05
				m.bit_en == {WORD_W{~m.sel_n[0]}}) else $error("single lane mask wrong");
		end else begin : g_four
			a_all_low: assert property (@(posedge m.clk) disable iff (!m.rst_n) // R06
				m.sel_n == 4'h0 |-> &m.bit_en) else $error("all low not full");
			a_lane_two: assert property (@(posedge m.clk) disable iff (!m.rst_n) // R07
				m.bit_en[26:18] == {9{~m.sel_n[2]}} && m.bit_en[35:27] == {9{~m.sel_n[3]}})
				else $error("upper lanes mask wrong");
			a_all_high: assert property (@(posedge m.clk) disable iff (!m.rst_n) // R08
				m.sel_n == 4'hf |-> m.bit_en == '0) else $error("all high wrote");
		end
	endgenerate

endmodule : sbwm_lane_mask

/* sbwm_top.sv */
/*
 * sbwm_top: write data path of a two-beat burst memory with per-lane write masking.
 * assumes: k_rise and kn_rise are one-cycle pulses marking the rising edges of the
 * positive and negative input clocks, never high together; inputs are synchronous.
 */
// Summary of operation
// R01 - 8/18-bit: both selects low write the whole beat.
// R02 - select 0 low, 1 high: only lower half of the beat written.
// R03 - select 0 high, 1 low: only upper half of the beat written.
// R04 - 8/18-bit: both selects high leave stored contents unaltered.
// R05 - 9-bit: one select per beat, low writes bits 8..0, high writes nothing.
// R06 - 36-bit: all four selects low write all 36 bits.
// R07 - 36-bit: select n governs 9-bit lane n; high keeps the stored lane.
// R08 - 36-bit: all four selects high write nothing.
// R09 - selects may differ between the two beats; each beat uses its own.
// R10 - selects are sampled with each data beat, on both clock edges.
// R11 - controller starts a write with load strobe and read/write low at K rise.
// R12 - beat one at next K rise after address, beat two at following K-bar rise.
// R13 - selects ignored at edges carrying no pending write beat.
`timescale 1ns/10ps
`include "sbwm_defs.svh"

module sbwm_top #(
	parameter int WORD_W = `SBWM_WORD_W,
	parameter int ADDR_W = `SBWM_ADDR_W
) (
	input wire logic ref_clk,
	input wire logic rstn,
	input wire logic k_rise,
	input wire logic kn_rise,
	input wire logic load_strobe_n,
	input wire logic rw_n,
	input wire logic [ADDR_W-1:0] addr,
	input wire logic [WORD_W-1:0] wdata,
	input wire logic [`SBWM_SEL_W-1:0] byte_lane_select_n,
	input wire logic [ADDR_W:0] rd_addr,
	output logic [WORD_W-1:0] rd_data,
	output logic wr_done,
	output logic wr_second,
	output logic [ADDR_W:0] wr_word_addr
);
	localparam int DEPTH = 2 ** (ADDR_W + 1);

	// ****************************************
	// declarations
	// ****************************************
	logic [WORD_W-1:0] mem [DEPTH];
	logic pend0_q;
	logic pend0_d;
	logic pend1_q;
	logic pend1_d;
	logic [ADDR_W-1:0] addr0_q;
	logic [ADDR_W-1:0] addr0_d;
	logic [ADDR_W-1:0] addr1_q;
	logic [ADDR_W-1:0] addr1_d;
	sbwm_pkg::sbwm_beat_e beat;
	logic [ADDR_W:0] wa;
	logic [WORD_W-1:0] wword;
	logic [WORD_W-1:0] rd_data_q;
	logic [WORD_W-1:0] rd_data_d;
	logic wr_done_q;
	logic wr_done_d;
	logic wr_second_q;
	logic wr_second_d;
	logic [ADDR_W:0] wr_addr_q;
	logic [ADDR_W:0] wr_addr_d;
	logic [WORD_W-1:0] chk_mask_q;
	logic [WORD_W-1:0] chk_data_q;
	logic [WORD_W-1:0] chk_old_q;

	sbwm_lane_if #(.WORD_W(WORD_W)) lane_if ();

	// ****************************************
	// lane mask expander
	// ****************************************
	assign lane_if.clk = ref_clk;
	assign lane_if.rst_n = rstn;
	// R13 selects only meaningful on a beat
	assign lane_if.sel_n = (beat == sbwm_pkg::SBWM_BEAT_NONE) ?
		`SBWM_SEL_IDLE : byte_lane_select_n;

	sbwm_lane_mask #(.WORD_W(WORD_W)) u_mask (
		.m(lane_if.lane)
	);

	// ****************************************
	// beat tracking
	// ****************************************
	always_comb begin
		pend0_d = pend0_q;
		pend1_d = pend1_q;
		addr0_d = addr0_q;
		addr1_d = addr1_q;
		beat = sbwm_pkg::SBWM_BEAT_NONE;
		wa = '0;
		// R12 second beat on K-bar rise
		if (kn_rise && pend1_q) begin
			beat = sbwm_pkg::SBWM_BEAT_SECOND;
			wa = {addr1_q, 1'b1};
			pend1_d = 1'b0;
		end
		if (k_rise) begin
			// R12 first beat on next K rise
			if (pend0_q) begin
				beat = sbwm_pkg::SBWM_BEAT_FIRST;
				wa = {addr0_q, 1'b0};
				pend1_d = 1'b1;
				addr1_d = addr0_q;
			end
			// R11 write start on load and write low
			pend0_d = !load_strobe_n && !rw_n;
			if (!load_strobe_n && !rw_n) begin
				addr0_d = addr;
			end
		end
	end

	// ****************************************
	// masked merge and result flags
	// ****************************************
	always_comb begin
		// R10 each beat masked by its own selects
		wword = (mem[wa] & ~lane_if.bit_en) | (wdata & lane_if.bit_en);
		wr_done_d = (beat != sbwm_pkg::SBWM_BEAT_NONE);
		wr_second_d = (beat == sbwm_pkg::SBWM_BEAT_SECOND);
		wr_addr_d = wr_done_d ? wa : wr_addr_q;
		rd_data_d = mem[rd_addr];
	end

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			pend0_q <= 1'b0;
			pend1_q <= 1'b0;
			addr0_q <= '0;
			addr1_q <= '0;
			wr_done_q <= 1'b0;
			wr_second_q <= 1'b0;
			wr_addr_q <= '0;
			rd_data_q <= '0;
		end else begin
			pend0_q <= pend0_d;
			pend1_q <= pend1_d;
			addr0_q <= addr0_d;
			addr1_q <= addr1_d;
			wr_done_q <= wr_done_d;
			wr_second_q <= wr_second_d;
			wr_addr_q <= wr_addr_d;
			rd_data_q <= rd_data_d;
		end
	end

	// ****************************************
	// storage array
	// ****************************************
	always_ff @(posedge ref_clk) begin
		if (wr_done_d) begin
			mem[wa] <= wword;
		end
	end

	assign rd_data = rd_data_q;
	assign wr_done = wr_done_q;
	assign wr_second = wr_second_q;
	assign wr_word_addr = wr_addr_q;

	// ****************************************
	// check helpers
	// ****************************************
	always_ff @(posedge ref_clk) begin
		chk_mask_q <= lane_if.bit_en;
		chk_data_q <= wdata;
		chk_old_q <= mem[wa];
	end

	// ****************************************
	// checks
	// ****************************************
	// R09 written lanes take the beat data
	a_lanes_written: assert property (@(posedge ref_clk) disable iff (!rstn) // R09
		wr_done_q |-> (mem[wr_addr_q] & chk_mask_q) == (chk_data_q & chk_mask_q))
		else $error("selected lanes not written");

	// R07 unselected lanes keep contents
	a_lanes_kept: assert property (@(posedge ref_clk) disable iff (!rstn) // R07
		wr_done_q |-> (mem[wr_addr_q] & ~chk_mask_q) == (chk_old_q & ~chk_mask_q))
		else $error("unselected lanes changed");

	// R10 all-high beat selects give an empty mask
	a_mask_source: assert property (@(posedge ref_clk) disable iff (!rstn) // R10
		wr_done_q && &$past(byte_lane_select_n) |-> chk_mask_q == '0)
		else $error("mask not from beat selects");

	// R12 second beat follows first
	a_beat_order: assert property (@(posedge ref_clk) disable iff (!rstn) // R12
		wr_done_q && wr_second_q |-> $past(pend1_q) && wr_addr_q[0])
		else $error("second beat without first");

	// R13 no write without a pending beat
	a_no_stray: assert property (@(posedge ref_clk) disable iff (!rstn) // R13
		!(k_rise && pend0_q) && !(kn_rise && pend1_q) |=> !wr_done_q)
		else $error("write outside a burst");

	// R11 load and address captured one cycle after K rise
	a_load_beat: assert property (@(posedge ref_clk) disable iff (!rstn) // R11
		k_rise && !load_strobe_n && !rw_n |=> pend0_q && addr0_q == $past(addr))
		else $error("write load not captured");

endmodule : sbwm_top

/* sbwm_ctl_model.sv */
/*
 * sbwm_ctl_model: write-side controller driving k/k-bar strobes, data and selects.
 * assumes: ref_clk runs free; wr is called only while reset is released.
 */
`timescale 1ns/10ps
module sbwm_ctl_model (
	input wire logic ref_clk,
	output logic k_rise,
	output logic kn_rise,
	output logic load_strobe_n,
	output logic rw_n,
	output logic [3:0] addr,
	output logic [35:0] wdata,
	output logic [3:0] byte_lane_select_n,
	output sbwm_pkg::sbwm_beat_e beat,
	output logic [3:0] beat_addr
);
	// ****************************************
	// drive helpers
	// ****************************************
	task automatic drv(input logic k, input logic kn, input logic ld, input logic rw,
		input logic [3:0] a, input logic [35:0] d, input logic [3:0] s,
		input sbwm_pkg::sbwm_beat_e b);
		k_rise = k;
		kn_rise = kn;
		load_strobe_n = ld;
		rw_n = rw;
		addr = a;
		wdata = d;
		byte_lane_select_n = s;
		beat = b;
	endtask : drv

	// idle lines show changing garbage, never the last value
	task automatic idle();
		@(posedge ref_clk) #1;
		drv(0, 0, 1, 1, ~addr, ~wdata, ~byte_lane_select_n, sbwm_pkg::SBWM_BEAT_NONE);
	endtask : idle

	initial begin
		beat_addr = '0;
		drv(0, 0, 1, 1, '0, '0, '1, sbwm_pkg::SBWM_BEAT_NONE);
	end

	// ****************************************
	// write burst
	// ****************************************
	task automatic wr(input logic [3:0] a, input logic rd, input logic [35:0] d0,
		input logic [35:0] d1, input logic [3:0] s0, input logic [3:0] s1);
		@(posedge ref_clk) #1;
		beat_addr = a;
		drv(1, 0, 0, rd, a, ~wdata, ~byte_lane_select_n, sbwm_pkg::SBWM_BEAT_NONE);
		idle();
		@(posedge ref_clk) #1;
		drv(1, 0, 1, 1, ~addr, d0, s0, rd ? sbwm_pkg::SBWM_BEAT_NONE : sbwm_pkg::SBWM_BEAT_FIRST);
		idle();
		@(posedge ref_clk) #1;
		drv(0, 1, 1, 1, ~addr, d1, s1, rd ? sbwm_pkg::SBWM_BEAT_NONE : sbwm_pkg::SBWM_BEAT_SECOND);
		idle();
	endtask : wr
endmodule : sbwm_ctl_model

/* sram_byte_write_mask_tb.sv */
/*
 * sram_byte_write_mask_tb: 8-, 9-, 18- and 36-bit write mask instances fed by one controller.
 * assumes: memory reads back through rd_addr with one cycle latency.
 */
`timescale 1ns/10ps
module sram_byte_write_mask_tb;
	logic ref_clk, rstn, k_rise, kn_rise, load_strobe_n, rw_n;
	logic [3:0] addr, sel, beat_addr;
	logic [35:0] wdata, rd36;
	logic [17:0] rd18;
	logic [7:0] rd8;
	logic [8:0] rd9;
	logic [4:0] rd_addr, wa8, wa9, wa18, wa36, wa_q;
	logic dn8, dn9, dn18, dn36, sc8, sc9, sc18, sc36;
	logic [35:0] e8 [32];
	logic [35:0] e9 [32];
	sbwm_pkg::sbwm_beat_e beat, bt_q;
	logic [35:0] e18 [32];
	logic [35:0] e36 [32];
	int bad_count = 0;
	int comparisons = 0;
	int cyc = 0;

	// ****************************************
	// instances and clock
	// ****************************************
	sbwm_ctl_model u_ctl (.ref_clk(ref_clk), .k_rise(k_rise), .kn_rise(kn_rise),
		.load_strobe_n(load_strobe_n), .rw_n(rw_n), .addr(addr), .wdata(wdata),
		.byte_lane_select_n(sel), .beat(beat), .beat_addr(beat_addr));
	sbwm_top #(.WORD_W(18)) u_dut (.ref_clk(ref_clk), .rstn(rstn), .k_rise(k_rise),
		.kn_rise(kn_rise), .load_strobe_n(load_strobe_n), .rw_n(rw_n), .addr(addr),
		.wdata(wdata[17:0]), .byte_lane_select_n(sel), .rd_addr(rd_addr), .rd_data(rd18),
		.wr_done(dn18), .wr_second(sc18), .wr_word_addr(wa18));
	sbwm_top #(.WORD_W(36)) u_dut_w36 (.ref_clk(ref_clk), .rstn(rstn), .k_rise(k_rise),
		.kn_rise(kn_rise), .load_strobe_n(load_strobe_n), .rw_n(rw_n), .addr(addr),
		.wdata(wdata), .byte_lane_select_n(sel), .rd_addr(rd_addr), .rd_data(rd36),
		.wr_done(dn36), .wr_second(sc36), .wr_word_addr(wa36));
	sbwm_top #(.WORD_W(8)) u_dut_w8 (.ref_clk(ref_clk), .rstn(rstn), .k_rise(k_rise),
		.kn_rise(kn_rise), .load_strobe_n(load_strobe_n), .rw_n(rw_n), .addr(addr),
		.wdata(wdata[7:0]), .byte_lane_select_n(sel), .rd_addr(rd_addr), .rd_data(rd8),
		.wr_done(dn8), .wr_second(sc8), .wr_word_addr(wa8));
	sbwm_top #(.WORD_W(9)) u_dut_w9 (.ref_clk(ref_clk), .rstn(rstn), .k_rise(k_rise),
		.kn_rise(kn_rise), .load_strobe_n(load_strobe_n), .rw_n(rw_n), .addr(addr),
		.wdata(wdata[8:0]), .byte_lane_select_n(sel), .rd_addr(rd_addr), .rd_data(rd9),
		.wr_done(dn9), .wr_second(sc9), .wr_word_addr(wa9));
	always #20 ref_clk = ~ref_clk;

	// ****************************************
	// checking helpers
	// ****************************************
	task automatic chk(input string nm, input logic [35:0] seen, input logic [35:0] exp);
		comparisons++;
		if (seen !== exp) begin
			bad_count++;
			$display("[ERR] %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk

	task automatic tally_and_finish();
		if (bad_count == 0 && comparisons > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : tally_and_finish

	function automatic logic [35:0] mrg(input logic [35:0] o, input logic [35:0] d,
		input logic [3:0] s, input int lanes, input int lw);
		logic [35:0] m;
		m = '0;
		for (int i = 0; i < lanes * lw; i++) begin
			if (!s[i / lw]) m[i] = 1'b1;
		end
		return (o & ~m) | (d & m);
	endfunction : mrg

	// expected beat strobes one cycle after each beat edge
	always @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			bt_q <= sbwm_pkg::SBWM_BEAT_NONE;
			wa_q <= '0;
		end else begin
			bt_q <= beat;
			if (beat != sbwm_pkg::SBWM_BEAT_NONE) wa_q <= {beat_addr, beat == sbwm_pkg::SBWM_BEAT_SECOND};
		end
	end

	always @(negedge ref_clk) begin
		if (rstn) begin
			chk("wr_done18", dn18, bt_q != sbwm_pkg::SBWM_BEAT_NONE);
			chk("wr_done36", dn36, bt_q != sbwm_pkg::SBWM_BEAT_NONE);
			chk("wr_word_addr18", wa18, wa_q);
			chk("wr_word_addr36", wa36, wa_q);
			chk("wr_done8", dn8, bt_q != sbwm_pkg::SBWM_BEAT_NONE);
			chk("wr_done9", dn9, bt_q != sbwm_pkg::SBWM_BEAT_NONE);
			chk("wr_word_addr8", wa8, wa_q);
			chk("wr_word_addr9", wa9, wa_q);
			if (bt_q != sbwm_pkg::SBWM_BEAT_NONE) begin
				chk("wr_second18", sc18, bt_q == sbwm_pkg::SBWM_BEAT_SECOND);
				chk("wr_second36", sc36, bt_q == sbwm_pkg::SBWM_BEAT_SECOND);
				chk("wr_second8", sc8, bt_q == sbwm_pkg::SBWM_BEAT_SECOND);
				chk("wr_second9", sc9, bt_q == sbwm_pkg::SBWM_BEAT_SECOND);
			end
		end
	end

	always @(posedge ref_clk) begin
		cyc <= cyc + 1;
		if (cyc == 5000) begin
			bad_count++;
			tally_and_finish();
		end
	end

	task automatic do_wr(input logic [3:0] a, input logic [35:0] d0, input logic [35:0] d1,
		input logic [3:0] s0, input logic [3:0] s1);
		u_ctl.wr(a, 1'b0, d0, d1, s0, s1);
		e18[{a, 1'b0}] = mrg(e18[{a, 1'b0}], d0, s0, 2, 9);
		e18[{a, 1'b1}] = mrg(e18[{a, 1'b1}], d1, s1, 2, 9);
		e36[{a, 1'b0}] = mrg(e36[{a, 1'b0}], d0, s0, 4, 9);
		e36[{a, 1'b1}] = mrg(e36[{a, 1'b1}], d1, s1, 4, 9);
		e8[{a, 1'b0}] = mrg(e8[{a, 1'b0}], d0, s0, 2, 4);
		e8[{a, 1'b1}] = mrg(e8[{a, 1'b1}], d1, s1, 2, 4);
		e9[{a, 1'b0}] = mrg(e9[{a, 1'b0}], d0, s0, 1, 9);
		e9[{a, 1'b1}] = mrg(e9[{a, 1'b1}], d1, s1, 1, 9);
	endtask : do_wr

	task automatic rdchk(input logic [3:0] a);
		for (int b = 0; b < 2; b++) begin
			rd_addr = {a, b[0]};
			@(posedge ref_clk) #1;
			chk("rd_data18", rd18, e18[{a, b[0]}][17:0]);
			chk("rd_data36", rd36, e36[{a, b[0]}]);
			chk("rd_data8", rd8, e8[{a, b[0]}][7:0]);
			chk("rd_data9", rd9, e9[{a, b[0]}][8:0]);
		end
	endtask : rdchk

	// ****************************************
	// scenarios
	// ****************************************
	task automatic t_full();
		for (int a = 0; a < 16; a++) begin
			do_wr(a[3:0], {9{a[3:0]}}, ~{9{a[3:0]}}, 4'h0, 4'h0);
			rdchk(a[3:0]);
		end
	endtask : t_full

	task automatic t_lanes();
		for (int s = 0; s < 16; s++) begin
			do_wr(s[3:0], ~{9{s[3:0]}}, {9{s[3:0]}}, s[3:0], ~s[3:0]);
			rdchk(s[3:0]);
		end
	endtask : t_lanes

	task automatic t_refused();
		u_ctl.wr(4'h5, 1'b1, '0, '0, 4'h0, 4'h0);
		rdchk(4'h5);
	endtask : t_refused

	task automatic t_reset();
		rstn = 1'b0;
		@(posedge ref_clk) #1;
		chk("rd_data18 reset", rd18, 36'h0);
		chk("rd_data36 reset", rd36, 36'h0);
		chk("wr_done reset", {dn18, dn36, wa18, wa36}, 36'h0);
		chk("narrow reset", {rd8, rd9, dn8, dn9, wa8, wa9}, 36'h0);
		rstn = 1'b1;
		do_wr(4'h7, 36'h0, '1, 4'h0, 4'he);
		rdchk(4'h7);
		rdchk(4'h6);
	endtask : t_reset

	initial begin
		ref_clk = 1'b0;
		rstn = 1'b0;
		rd_addr = '0;
		repeat (5) @(posedge ref_clk);
		#1 rstn = 1'b1;
		t_full();
		t_lanes();
		t_refused();
		t_reset();
		tally_and_finish();
	end
endmodule : sram_byte_write_mask_tb
